// >>> inc/sip_pkg.sv
// Shared constants for the serial identification memory link
package sip_pkg;
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          WR_TIME_MS     = 5;
  localparam int          WR_CYCLES      = WR_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          DATA_W         = 8;
  localparam int          ADDR_W         = 4;
  localparam int          DEPTH          = 16;
  localparam int          CMD_HI         = 7;
  localparam int          CMD_LO         = 6;
  localparam int          ADDR_HI        = 5;
  localparam int          ADDR_LO        = 2;
  localparam logic [1:0]  CMD_READ       = 2'h2;
  localparam logic [1:0]  CMD_PROG_DEF   = 2'h1;
  localparam logic [1:0]  DONT_CARE_BITS = 2'h0;
  localparam logic [3:0]  LAST_BIT       = 4'h7;
  localparam logic [3:0]  TURN_BIT       = 4'h7;
  localparam logic [3:0]  READ_BITS      = 4'h8;
  localparam logic [4:0]  FRAME_LAST     = 5'h0F;
  localparam logic [4:0]  FRAME_DATA     = 5'h08;
  localparam int          SCL_QTR_CYCLES = 4;
endpackage : sip_pkg

// >>> inc/sip_if.sv
// Two-wire link between master and memory, with data line resolution
`timescale 1ns/1ps
interface sip_if;
  logic scl;
  logic scl_hv;
  logic mst_sda_o;
  logic mst_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Undriven line reads high, as with a pull-up on the board
  assign sda = dev_sda_oe ? dev_sda_o : (mst_sda_oe ? mst_sda_o : 1'b1);

  modport mst (output scl, output scl_hv, output mst_sda_o, output mst_sda_oe, input sda);
  modport dev (input scl, input scl_hv, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : sip_if

// >>> src/sip_mst.sv
// Link master: makes the serial clock and runs read and program frames
`timescale 1ns/1ps
module sip_mst
  import sip_pkg::*;
#(
  parameter int         QTR       = SCL_QTR_CYCLES,
  parameter int         WR_WAIT   = WR_CYCLES,
  parameter logic [1:0] PGM_CMD   = CMD_PROG_DEF
)(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  // Link
  sip_if.mst                     bus,
  // User request
  input  wire logic              req_i,
  input  wire logic              prog_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  // User answer
  output logic                   busy_o,
  output logic                   done_o,
  output logic [DATA_W-1:0]      rdata_o
);
  import sip_pkg::*;

  localparam int QW = $clog2(QTR + 1);
  localparam int WW = $clog2(WR_WAIT + 1);

  typedef enum logic [2:0] {M_IDLE, M_START, M_BITS, M_STOP, M_WAIT} sip_mst_state_t;

  sip_mst_state_t    state, next_state;
  logic [QW-1:0]     qcnt, next_qcnt;
  logic [1:0]        ph, next_ph;
  logic [4:0]        bitn, next_bitn;
  logic [15:0]       sh, next_sh;
  logic [DATA_W-1:0] rd, next_rd, rdata, next_rdata;
  logic [WW-1:0]     wcnt, next_wcnt;
  logic              prog, next_prog;
  logic              scl, next_scl, hv, next_hv;
  logic              sda_o, next_sda_o, sda_oe, next_sda_oe;
  logic              busy, next_busy, done, next_done;
  logic [1:0]        sda_p, next_sda_p;
  logic              tick;

  assign tick = (qcnt == QW'(QTR - 1));

  always_comb
  begin
    next_sda_p  = {sda_p[0], bus.sda};
    next_state  = state;
    next_qcnt   = (state == M_IDLE || tick) ? '0 : qcnt + QW'(1);
    next_ph     = tick ? ph + 2'h1 : ph;
    next_bitn   = bitn;
    next_sh     = sh;
    next_rd     = rd;
    next_rdata  = rdata;
    next_wcnt   = wcnt;
    next_prog   = prog;
    next_scl    = scl;
    next_hv     = hv;
    next_sda_o  = sda_o;
    next_sda_oe = sda_oe;
    next_busy   = busy;
    next_done   = 1'b0;
    unique case (state)
      M_IDLE:
      begin
        next_scl    = 1'b1;
        next_sda_oe = 1'b0;
        next_ph     = 2'h0;
        // Master alone opens every transfer
        if (req_i)
        begin
          next_state  = M_START;
          next_busy   = 1'b1;
          next_prog   = prog_i;
          next_hv     = prog_i;  // High voltage on clock before data falls
          next_sda_o  = 1'b1;
          next_sda_oe = 1'b1;
          // Command, address, ignored bits, then data, msb first
          next_sh     = {prog_i ? PGM_CMD : CMD_READ, addr_i, DONT_CARE_BITS, wdata_i};
        end
      end
      M_START:
        if (tick)
        begin
          if (ph == 2'h1)
            next_sda_o = 1'b0;  // Data falls with clock high
          if (ph == 2'h3)
          begin
            next_state = M_BITS;
            next_scl   = 1'b0;
            next_hv    = 1'b0;
            next_bitn  = '0;
          end
        end
      M_BITS:
        if (tick)
        begin
          unique case (ph)
            2'h0:
            begin
              // Data moves a quarter after clock falls
              next_sda_o  = sh[15];
              next_sh     = {sh[14:0], 1'b0};
              // Read frame frees the line for the turnaround bit
              next_sda_oe = prog || (bitn < 5'(TURN_BIT));
            end
            2'h1: next_scl = 1'b1;
            2'h2: next_scl = 1'b1;
            2'h3:
            begin
              next_scl = 1'b0;
              if (!prog && bitn >= FRAME_DATA)
                next_rd = {rd[DATA_W-2:0], sda_p[1]};
              if (bitn == FRAME_LAST)
                next_state = M_STOP;
              else
                next_bitn = bitn + 5'h01;
            end
          endcase
        end
      M_STOP:
        if (tick)
        begin
          unique case (ph)
            // Wait a quarter so the memory has let go of the line
            2'h0:
            begin
              next_sda_o  = 1'b0;
              next_sda_oe = 1'b1;
            end
            2'h1: next_scl = 1'b1;
            2'h2: next_sda_o = 1'b1;
            2'h3:
            begin
              next_sda_oe = 1'b0;
              next_done   = 1'b1;
              next_rdata  = prog ? rdata : rd;
              next_wcnt   = '0;
              next_state  = prog ? M_WAIT : M_IDLE;
              next_busy   = prog;
            end
          endcase
        end
      M_WAIT:
      begin
        // One byte per sequence, then a full write cycle time
        next_wcnt = wcnt + WW'(1);
        if (wcnt == WW'(WR_WAIT - 1))
        begin
          next_state = M_IDLE;
          next_busy  = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      state  <= M_IDLE;
      qcnt   <= '0;
      ph     <= 2'h0;
      bitn   <= '0;
      sh     <= '0;
      rd     <= '0;
      rdata  <= '0;
      wcnt   <= '0;
      prog   <= 1'b0;
      scl    <= 1'b1;
      hv     <= 1'b0;
      sda_o  <= 1'b1;
      sda_oe <= 1'b0;
      busy   <= 1'b0;
      done   <= 1'b0;
      sda_p  <= 2'h3;
    end
    else
    begin
      state  <= next_state;
      qcnt   <= next_qcnt;
      ph     <= next_ph;
      bitn   <= next_bitn;
      sh     <= next_sh;
      rd     <= next_rd;
      rdata  <= next_rdata;
      wcnt   <= next_wcnt;
      prog   <= next_prog;
      scl    <= next_scl;
      hv     <= next_hv;
      sda_o  <= next_sda_o;
      sda_oe <= next_sda_oe;
      busy   <= next_busy;
      done   <= next_done;
      sda_p  <= next_sda_p;
    end
  end

  assign bus.scl        = scl;
  assign bus.scl_hv     = hv;
  assign bus.mst_sda_o  = sda_o;
  assign bus.mst_sda_oe = sda_oe;
  assign busy_o         = busy;
  assign done_o         = done;
  assign rdata_o        = rdata;
endmodule : sip_mst

// >>> src/sip_dev.sv
// Serial identification memory: 16 x 8 slave on the two-wire link
// Operation
// - Data changes only with clock low
// - Ignore everything until a start is seen
// - Start aborts command or data input
// - No starts while driving or writing
// - Stop during input returns to standby
// - No stops while driving or writing
// - Master programs one byte, waits write time
// - Program start needs high voltage clock
// - Program word then data byte follows
// - Either clock-high level valid after program start
// - Read control byte: 1,0, address, two ignored
// - Load addressed byte, shift out eight bits
// - After eighth bit, clear counters, standby
// - Start or stop cancels read command
// - Turnaround bit ignores start and stop
// - Master frees line before turnaround ends
// - Drive both levels when sending data
// - Never drive line while programming
// - Master opens transfers and makes clock
// - Array holds sixteen eight-bit bytes
// - Write cycle: interface off, line undriven
`timescale 1ns/1ps
module sip_dev
  import sip_pkg::*;
#(
  parameter int         WR_WAIT = WR_CYCLES,
  parameter logic [1:0] PGM_CMD = CMD_PROG_DEF
)(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // Link
  sip_if.dev        bus,
  // Status
  output logic      write_busy_o,
  output logic      read_active_o
);
  import sip_pkg::*;

  localparam int WW = $clog2(WR_WAIT + 1);

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_READ, ST_PDATA, ST_WRITE, ST_IGNORE
  } sip_dev_state_t;

  sip_dev_state_t    state, next_state;
  logic [3:0]        cnt, next_cnt;
  logic [DATA_W-1:0] sreg, next_sreg;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [WW-1:0]     wcnt, next_wcnt;
  logic              pgm, next_pgm;
  logic              sda_o, next_sda_o, sda_oe, next_sda_oe;
  logic              wbusy, next_wbusy, ractive, next_ractive;
  logic [2:0]        scl_p, next_scl_p, sda_p, next_sda_p;
  logic [1:0]        hv_p, next_hv_p;
  logic              mem_we;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] in_byte;
  logic              scl_s, scl_q, sda_s, sda_q, hv_s;
  logic              start_ev, stop_ev, rise, fall, cond_ok;

  // Stage 0 of each chain feeds only stage 1
  assign scl_s = scl_p[1];
  assign scl_q = scl_p[2];
  assign sda_s = sda_p[1];
  assign sda_q = sda_p[2];
  assign hv_s  = hv_p[1];

  // Data moving under clock high is a framing condition
  assign start_ev = scl_s && scl_q && sda_q && !sda_s;
  assign stop_ev  = scl_s && scl_q && !sda_q && sda_s;
  // Clock high is one logic level whatever the voltage behind it
  assign rise     = scl_s && !scl_q;
  assign fall     = !scl_s && scl_q;
  assign in_byte  = {sreg[DATA_W-2:0], sda_s};
  // Turnaround bit of a read command ignores framing
  assign cond_ok  = !(state == ST_CMD && !pgm && cnt == TURN_BIT);

  always_comb
  begin
    next_scl_p   = {scl_p[1:0], bus.scl};
    next_sda_p   = {sda_p[1:0], bus.sda};
    next_hv_p    = {hv_p[0], bus.scl_hv};
    next_state   = state;
    next_cnt     = cnt;
    next_sreg    = sreg;
    next_addr    = addr;
    next_wcnt    = wcnt;
    next_pgm     = pgm;
    next_sda_o   = sda_o;
    next_sda_oe  = sda_oe;
    next_wbusy   = wbusy;
    next_ractive = ractive;
    mem_we       = 1'b0;
    unique case (state)
      // Only a start leaves standby or an ignored command
      ST_IDLE, ST_IGNORE:
        if (start_ev)
        begin
          next_state = ST_CMD;
          next_cnt   = '0;
          next_pgm   = hv_s;  // High voltage marks a program start
        end
      ST_CMD, ST_PDATA:
        if (cond_ok && start_ev)
        begin
          // Abort input, ready for a fresh command
          next_state = ST_CMD;
          next_cnt   = '0;
          next_pgm   = hv_s;
        end
        else if (cond_ok && stop_ev)
        begin
          next_state = ST_IDLE;
          next_cnt   = '0;
        end
        else if (rise)
        begin
          next_sreg = in_byte;  // Msb first
          next_cnt  = cnt + 4'h1;
          if (cnt == LAST_BIT && state == ST_PDATA)
          begin
            // Byte follows the program word directly
            next_state = ST_WRITE;
            next_wcnt  = '0;
            next_wbusy = 1'b1;
          end
          else if (cnt == LAST_BIT)
          begin
            next_addr = in_byte[ADDR_HI:ADDR_LO];
            next_cnt  = '0;
            if (pgm && in_byte[CMD_HI:CMD_LO] == PGM_CMD)
              next_state = ST_PDATA;
            else if (!pgm && in_byte[CMD_HI:CMD_LO] == CMD_READ)
            begin
              // Load array byte for shift-out
              next_state   = ST_READ;
              next_sreg    = mem[in_byte[ADDR_HI:ADDR_LO]];
              next_ractive = 1'b1;
            end
            else
              next_state = ST_IGNORE;
          end
        end
      // Framing is not watched while driving
      ST_READ:
        if (fall)
        begin
          if (cnt == READ_BITS)
          begin
            // Line freed only after the master sampled the last bit
            next_state   = ST_IDLE;
            next_cnt     = '0;
            next_sda_oe  = 1'b0;
            next_ractive = 1'b0;
          end
          else
          begin
            next_sda_o  = sreg[DATA_W-1];  // Push-pull, both levels
            next_sda_oe = 1'b1;
            next_sreg   = {sreg[DATA_W-2:0], 1'b0};
            next_cnt    = cnt + 4'h1;
          end
        end
      ST_WRITE:
      begin
        // Deaf to the link for the whole write cycle
        next_wcnt = wcnt + WW'(1);
        if (wcnt == WW'(WR_WAIT - 1))
        begin
          mem_we     = 1'b1;
          next_state = ST_IDLE;
          next_cnt   = '0;
          next_wbusy = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      state   <= ST_IDLE;
      cnt     <= '0;
      sreg    <= '0;
      addr    <= '0;
      wcnt    <= '0;
      pgm     <= 1'b0;
      sda_o   <= 1'b1;
      sda_oe  <= 1'b0;
      wbusy   <= 1'b0;
      ractive <= 1'b0;
      scl_p   <= 3'h7;
      sda_p   <= 3'h7;
      hv_p    <= 2'h0;
    end
    else
    begin
      state   <= next_state;
      cnt     <= next_cnt;
      sreg    <= next_sreg;
      addr    <= next_addr;
      wcnt    <= next_wcnt;
      pgm     <= next_pgm;
      sda_o   <= next_sda_o;
      sda_oe  <= next_sda_oe;
      wbusy   <= next_wbusy;
      ractive <= next_ractive;
      scl_p   <= next_scl_p;
      sda_p   <= next_sda_p;
      hv_p    <= next_hv_p;
    end
  end

  // Array is nonvolatile in spirit, so reset leaves it alone
  always_ff @(posedge sys_clk_i)
  begin
    if (mem_we)
      mem[addr] <= sreg;
  end

  assign bus.dev_sda_o  = sda_o;
  assign bus.dev_sda_oe = sda_oe;
  assign write_busy_o   = wbusy;
  assign read_active_o  = ractive;
endmodule : sip_dev

// >>> bench/sip_monitor.sv
// Checker on the link joining master and memory
`timescale 1ns/1ps
module sip_monitor (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Link
  input wire logic scl,
  input wire logic scl_hv,
  input wire logic mst_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       hv;
  logic [4:0] bits;
  logic [7:0] ctl;
  logic [3:0] oes;
  logic       rise;
  logic       turn;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  assign rise = scl && !scl_q;
  // Raw wires, no sync delay, so rises line up with the master's own
  assign turn = rise && bits == 5'h07 && ctl[6:5] == 2'h2 && !hv;

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      hv    <= 1'b0;
      bits  <= 5'h00;
      ctl   <= 8'h00;
      oes   <= 4'h0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda)
      begin
        bits <= 5'h00;
        hv   <= scl_hv;
      end
      else if (rise && bits != 5'h1F)
        bits <= bits + 5'h01;
      if (rise && bits < 5'h08)
        ctl <= {ctl[6:0], sda};
      oes <= !dev_sda_oe ? 4'h0 : (rise ? oes + 4'h1 : oes);
    end
  end

  AST_NO_CLASH: assert property (!(dev_sda_oe && mst_sda_oe))
    else $error("both ends drive the data line");
  AST_SDA_STEADY: assert property (scl && $past(scl) && bits inside {[1:16]} |-> $stable(sda))
    else $error("data moved while clock high");
  AST_HV_QUIET: assert property (hv |-> !dev_sda_oe)
    else $error("device drove during program frame");
  AST_RD_CAUSE: assert property ($rose(dev_sda_oe) |-> bits == 5'h08 && ctl[7:6] == 2'h2 && !hv && !scl)
    else $error("device drove without a read byte");
  AST_RD_COUNT: assert property ($fell(dev_sda_oe) |-> oes == 4'h8 && !scl)
    else $error("read length wrong");
  AST_MST_FREE: assert property (turn |-> !mst_sda_oe)
    else $error("master held line at turnaround");
  AST_RD_ANSWER: assert property (turn |-> ##[1:40] dev_sda_oe)
    else $error("no read data");
  AST_HV_LEVEL: assert property (scl_hv |-> scl)
    else $error("program level without clock high");

  cover property ($rose(dev_sda_oe));
  cover property ($rose(hv));
  cover property ($fell(dev_sda_oe));
endmodule : sip_monitor

// >>> bench/tb.sv
// Self-checking bench: master and memory, plus a memory driven directly
`timescale 1ns/1ps
module tb;
  import sip_pkg::*;
  logic              sys_clk_i;
  logic              nrst_i;
  logic              req_i;
  logic              prog_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic              busy_o;
  logic              done_o;
  logic [DATA_W-1:0] rdata_o;
  logic              wbusy2;
  logic              ract2;
  logic              hv;
  logic              ld;
  logic              le;
  logic [DATA_W-1:0] img [DEPTH];
  logic [8:0]        notes [$];
  logic [8:0]        n9;
  logic [DATA_W-1:0] got;
  logic [DATA_W-1:0] pd;
  int                fails = 0;
  int                cmp_count = 0;
  int                oe_seen = 0;
  int                snap;

  sip_if bus1 ();
  sip_if bus2 ();
  sip_mst #(.QTR(4), .WR_WAIT(40)) sip_mst_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .bus(bus1), .req_i(req_i), .prog_i(prog_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o));
  sip_dev #(.WR_WAIT(20)) sip_dev_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus(bus1),
    .write_busy_o(), .read_active_o());
  // Long write so traffic can be sent into it
  sip_dev #(.WR_WAIT(400)) sip_dev_inst_b (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus(bus2),
    .write_busy_o(wbusy2), .read_active_o(ract2));
  sip_monitor sip_monitor_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .scl(bus1.scl),
    .scl_hv(bus1.scl_hv), .mst_sda_oe(bus1.mst_sda_oe), .dev_sda_oe(bus1.dev_sda_oe),
    .sda(bus1.sda));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch at %0t: data %h expected %h", $time, g, e);
    end
  endtask : cmp8

  task automatic cmp1(input logic g, input logic e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch at %0t: flag %b expected %b", $time, g, e);
    end
  endtask : cmp1

  task automatic wait_low(input logic w);
    int n;
    n = 0;
    do
    begin
      @(negedge sys_clk_i);
      n++;
    end
    while ((w ? wbusy2 : busy_o) !== 1'b0 && n < 2000);
    if (n >= 2000)
    begin
      fails++;
      give_verdict();
    end
  endtask : wait_low

  task automatic frame(input logic p, input logic [3:0] a, input logic [7:0] d);
    wait_low(1'b0);
    @(posedge sys_clk_i);
    req_i   <= 1'b1;
    prog_i  <= p;
    addr_i  <= a;
    wdata_i <= d;
    if (p)
      img[a] = d;
    notes.push_back({!p, img[a]});
    @(posedge sys_clk_i);
    req_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
  endtask : frame

  // Results leave in issue order, so the oldest note matches
  always @(negedge sys_clk_i)
    if (done_o === 1'b1)
    begin
      n9 = notes.pop_front();
      if (n9[8])
        cmp8(rdata_o, n9[7:0]);
    end

  always @(posedge sys_clk_i)
    if (bus2.dev_sda_oe === 1'b1)
      oe_seen++;

  // One quarter of the 800 ns bench clock
  task automatic drv(input logic c, input logic d, input logic e);
    repeat (2) @(posedge sys_clk_i);
    bus2.scl        <= c;
    bus2.scl_hv     <= c & hv;
    bus2.mst_sda_o  <= d;
    bus2.mst_sda_oe <= e;
    ld = d;
    le = e;
  endtask : drv

  task automatic bit2(input logic d, input logic e);
    drv(1'b0, ld, le);
    drv(1'b0, d, e);
    drv(1'b1, d, e);
    drv(1'b1, d, e);
    got = {got[6:0], bus2.sda};
  endtask : bit2

  task automatic start2();
    drv(1'b0, 1'b1, 1'b1);
    drv(1'b1, 1'b1, 1'b1);
    drv(1'b1, 1'b0, 1'b1);
  endtask : start2

  task automatic stop2();
    drv(1'b0, 1'b0, 1'b1);
    drv(1'b1, 1'b0, 1'b1);
    drv(1'b1, 1'b1, 1'b1);
    drv(1'b1, 1'b1, 1'b0);
  endtask : stop2

  task automatic send2(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--)
      bit2(v[i], 1'b1);
  endtask : send2

  initial
  begin
    void'($urandom(32'hEAD0CA50));
    nrst_i          = 1'b0;
    req_i           = 1'b0;
    prog_i          = 1'b0;
    addr_i          = 4'h0;
    wdata_i         = 8'h00;
    hv              = 1'b0;
    ld              = 1'b1;
    le              = 1'b0;
    bus2.scl        = 1'b1;
    bus2.scl_hv     = 1'b0;
    bus2.mst_sda_o  = 1'b1;
    bus2.mst_sda_oe = 1'b0;
    repeat (20) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < DEPTH; i++)
      frame(1'b1, 4'(i), (i == 0) ? 8'h00 : (i == 15) ? 8'hFF : 8'($urandom));
    for (int i = 0; i < DEPTH; i++)
      frame(1'b0, 4'($urandom), 8'h00);
    frame(1'b1, 4'h5, 8'hA5);
    frame(1'b0, 4'h5, 8'h00);
    wait_low(1'b0);
    repeat (4) @(negedge sys_clk_i);
    cmp1(notes.size() == 0, 1'b1);
    send2(8'h80, 8);
    cmp1(ract2, 1'b0);
    snap = oe_seen;
    hv = 1'b1;
    start2();
    hv = 1'b0;
    pd = 8'($urandom);
    send2({CMD_PROG_DEF, 4'hA, 2'h0}, 8);
    send2(pd, 8);
    stop2();
    cmp1(wbusy2, 1'b1);
    start2();
    send2({CMD_READ, 4'hA, 2'h0}, 8);
    stop2();
    cmp1(ract2, 1'b0);
    cmp1(oe_seen == snap, 1'b1);
    wait_low(1'b1);
    start2();
    send2(8'hB0, 3);
    start2();
    send2({CMD_READ, 4'hA, 2'h0}, 7);
    drv(1'b0, ld, le);
    drv(1'b0, 1'b1, 1'b1);
    drv(1'b1, 1'b1, 1'b1);
    drv(1'b1, 1'b0, 1'b1);
    ld = 1'b1;
    le = 1'b0;
    repeat (8) bit2(1'b1, 1'b0);
    cmp8(got, pd);
    drv(1'b0, 1'b1, 1'b0);
    repeat (6) @(negedge sys_clk_i);
    cmp1(bus2.dev_sda_oe, 1'b0);
    start2();
    send2({CMD_READ, 4'hA, 2'h0}, 4);
    stop2();
    snap = oe_seen;
    send2({CMD_READ, 4'hA, 2'h0}, 8);
    repeat (8) bit2(1'b1, 1'b0);
    cmp1(oe_seen == snap, 1'b1);
    start2();
    send2({2'h3, 4'hA, 2'h0}, 8);
    repeat (8) bit2(1'b1, 1'b0);
    cmp1(oe_seen == snap, 1'b1);
    give_verdict();
  end
endmodule : tb
